// ### core/prog_host.sv
// Programmer end of the serial programming link: makes the link clock,
// sends commands and canned read sequences, reads words and responses,
// checks the executive identity and times row program/erase cycles.
// Assumes the device samples on rising link clock edges and drives data
// after them; this end samples on its own falling edges.
`timescale 1ns/10ps
module prog_host #(
  parameter int HALF_CYC  = 8,
  parameter int PLAIN_CYC = prog_link_pkg::ROW_PLAIN_CYC,
  parameter int ENH_CYC   = prog_link_pkg::ROW_ENH_CYC,
  parameter int EXIT_CYC  = 16
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  prog_link_if.programmer  lnk,
  input  wire logic        cmd_valid_i,
  input  prog_link_pkg::op_t cmd_op_i,
  input  wire logic [23:0] cmd_data_i,
  input  wire logic        cmd_enh_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,
  output logic             exec_resident_o,
  output logic             exec_load_needed_o,
  output logic             verify_error_o
);

  typedef enum logic [2:0] {
    H_IDLE, H_FETCH, H_CLOCK, H_RESP_LO, H_RESP_HI, H_COUNT
  } hstate_t;

  hstate_t              st_r;
  prog_link_pkg::op_t   op_r;
  logic [5:0]           idx_r;
  logic [5:0]           last_r;
  logic                 seq_r;
  logic [27:0]          tx_r;
  logic [4:0]           nbits_r;
  logic                 sample_r;
  logic                 then_read_r;
  logic [15:0]          rx_r;
  logic [15:0]          cmp_r;
  logic [7:0]           half_r;
  logic                 pgc_r;
  logic                 doe_r;
  logic                 master_clear_pin_n_r;
  logic [31:0]          cnt_r;
  logic [11:0]          gap_r;
  logic [1:0]           pgd_s_r;
  logic                 rsp_valid_r;
  logic [15:0]          rsp_data_r;
  logic                 resident_r;
  logic                 load_needed_r;
  logic                 verr_r;

  // Canned sequences; entries past the body are no-ops between reads
  function automatic logic [27:0] seq_item(input logic [5:0] idx);
    logic [5:0]  k;
    logic [23:0] w;
    k = idx - prog_link_pkg::SEQ_EXEC_BODY;
    w = prog_link_pkg::INSN_NOP;
    unique case (idx)
      6'h00, 6'h01, 6'h10, 6'h11: w = prog_link_pkg::INSN_GOTO_RESET;
      6'h03, 6'h13:               w = prog_link_pkg::INSN_PAGE_LIT;
      6'h04, 6'h14:               w = prog_link_pkg::INSN_W0_TO_PAGE;
      6'h05:                      w = prog_link_pkg::INSN_PTR_LIT;
      6'h06:                      w = prog_link_pkg::INSN_VIS_TARGET;
      6'h08:                      w = prog_link_pkg::INSN_RD_LOW_ID;
      6'h0B:                      return {prog_link_pkg::CODE_SHIFT_OUT, 24'h000000};
      6'h15:                      w = prog_link_pkg::INSN_CLR_RD_PTR;
      6'h16:                      w = prog_link_pkg::INSN_CLR_WR_PTR;
      default: begin
        if (idx >= prog_link_pkg::SEQ_EXEC_BODY && (k % 6'h03) == 6'h00) begin
          unique case ((k / 6'h03) & 6'h03)
            6'h00:   w = prog_link_pkg::INSN_RDL_KEEP;
            6'h01:   w = prog_link_pkg::INSN_RDH_INC;
            6'h02:   w = prog_link_pkg::INSN_RDH_PREINC;
            default: w = prog_link_pkg::INSN_RDL_INC;
          endcase
        end
      end
    endcase
    return {prog_link_pkg::CODE_EXEC, w};
  endfunction : seq_item

  wire [27:0] item     = seq_item(idx_r);
  wire        pgd_s    = pgd_s_r[1];
  wire        half_end = (half_r == 8'h00);
  wire        fall_now = half_end & pgc_r;
  wire        last_bit = (nbits_r == 5'h01);
  wire [15:0] rx_nxt   = {pgd_s, rx_r[15:1]};
  wire        seq_more = seq_r & (idx_r != last_r);

  assign cmd_ready_o        = (st_r == H_IDLE);
  assign rsp_valid_o        = rsp_valid_r;
  assign rsp_data_o         = rsp_data_r;
  assign exec_resident_o    = resident_r;
  assign exec_load_needed_o = load_needed_r;
  assign verify_error_o     = verr_r;
  assign lnk.programming_clock_pin            = pgc_r;
  assign lnk.host_dout      = tx_r[0];
  assign lnk.host_doe       = doe_r;
  assign lnk.master_clear_pin_n         = master_clear_pin_n_r;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pgd_s_r <= 2'h3;
    end else begin
      pgd_s_r <= {pgd_s_r[0], lnk.pgd_level};
    end
  end

  // Inter-word spacing runs on its own so user delays count towards it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_r <= 12'h000;
    end else if (st_r == H_CLOCK && fall_now && last_bit && sample_r &&
                 op_r == prog_link_pkg::OP_RESPONSE) begin
      gap_r <= 12'(prog_link_pkg::INTER_WORD_CYC);
    end else if (gap_r != 12'h000) begin
      gap_r <= gap_r - 12'h001;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r          <= H_IDLE;
      op_r          <= prog_link_pkg::OP_EXEC;
      idx_r         <= 6'h00;
      last_r        <= 6'h00;
      seq_r         <= 1'b0;
      tx_r          <= 28'h0000000;
      nbits_r       <= 5'h00;
      sample_r      <= 1'b0;
      then_read_r   <= 1'b0;
      rx_r          <= 16'h0000;
      cmp_r         <= 16'h0000;
      half_r        <= 8'h00;
      pgc_r         <= 1'b0;
      doe_r         <= 1'b0;
      master_clear_pin_n_r      <= 1'b0;
      cnt_r         <= 32'h00000000;
      rsp_valid_r   <= 1'b0;
      rsp_data_r    <= 16'h0000;
      resident_r    <= 1'b0;
      load_needed_r <= 1'b0;
      verr_r        <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      master_clear_pin_n_r    <= 1'b1;
      unique case (st_r)
        H_IDLE: begin
          if (cmd_valid_i) begin
            op_r     <= cmd_op_i;
            seq_r    <= 1'b0;
            sample_r <= 1'b0;
            half_r   <= 8'(HALF_CYC - 1);
            cmp_r    <= cmd_data_i[15:0];
            unique case (cmd_op_i)
              prog_link_pkg::OP_EXEC: begin
                tx_r        <= {cmd_data_i, prog_link_pkg::CODE_EXEC};
                nbits_r     <= prog_link_pkg::CMD_BITS;
                then_read_r <= 1'b0;
                st_r        <= H_CLOCK;
              end
              prog_link_pkg::OP_SHIFT_OUT, prog_link_pkg::OP_VERIFY: begin
                tx_r        <= {24'h000000, prog_link_pkg::CODE_SHIFT_OUT};
                nbits_r     <= prog_link_pkg::CODE_BITS;
                then_read_r <= 1'b1;
                st_r        <= H_CLOCK;
              end
              prog_link_pkg::OP_ID_CHECK: begin
                idx_r  <= prog_link_pkg::SEQ_ID_FIRST;
                last_r <= prog_link_pkg::SEQ_ID_LAST;
                seq_r  <= 1'b1;
                st_r   <= H_FETCH;
              end
              prog_link_pkg::OP_EXEC_READ: begin
                idx_r  <= prog_link_pkg::SEQ_EXEC_FIRST;
                last_r <= prog_link_pkg::SEQ_EXEC_LAST;
                seq_r  <= 1'b1;
                st_r   <= H_FETCH;
              end
              prog_link_pkg::OP_RESPONSE: st_r <= H_RESP_LO;
              prog_link_pkg::OP_ROW_WAIT: begin
                // Waits the longest cycle time so any part has finished
                cnt_r <= cmd_enh_i ? 32'(ENH_CYC) : 32'(PLAIN_CYC);
                st_r  <= H_COUNT;
              end
              prog_link_pkg::OP_EXIT: begin
                master_clear_pin_n_r <= 1'b0;
                cnt_r    <= 32'(EXIT_CYC);
                st_r     <= H_COUNT;
              end
            endcase
          end
        end
        H_FETCH: begin
          tx_r        <= {item[23:0], item[27:24]};
          then_read_r <= (item[27:24] == prog_link_pkg::CODE_SHIFT_OUT);
          nbits_r     <= (item[27:24] == prog_link_pkg::CODE_SHIFT_OUT) ?
                         prog_link_pkg::CODE_BITS : prog_link_pkg::CMD_BITS;
          sample_r    <= 1'b0;
          half_r      <= 8'(HALF_CYC - 1);
          st_r        <= H_CLOCK;
        end
        H_RESP_LO: begin
          if (!pgd_s) begin
            st_r <= H_RESP_HI;
          end
        end
        H_RESP_HI: begin
          if (pgd_s) begin
            cnt_r <= 32'(prog_link_pkg::REL_CLK_CYC);
            st_r  <= H_COUNT;
          end
        end
        H_COUNT: begin
          if (op_r == prog_link_pkg::OP_EXIT) begin
            master_clear_pin_n_r <= 1'b0;
          end
          if (cnt_r != 32'h00000000) begin
            cnt_r <= cnt_r - 32'h00000001;
          end else if (op_r == prog_link_pkg::OP_RESPONSE) begin
            if (gap_r == 12'h000) begin
              sample_r <= 1'b1;
              nbits_r  <= prog_link_pkg::RSP_BITS;
              half_r   <= 8'(HALF_CYC - 1);
              st_r     <= H_CLOCK;
            end
          end else begin
            master_clear_pin_n_r <= 1'b1;
            st_r     <= H_IDLE;
          end
        end
        H_CLOCK: begin
          half_r <= half_end ? 8'(HALF_CYC - 1) : half_r - 8'h01;
          // Drive from mid low phase: the device frees the pin late after a read
          if (!sample_r && half_r == 8'(HALF_CYC / 2)) begin
            doe_r <= 1'b1;
          end
          if (half_end) begin
            pgc_r <= ~pgc_r;
          end
          if (fall_now) begin
            nbits_r <= nbits_r - 5'h01;
            if (sample_r) begin
              rx_r <= rx_nxt;
            end else begin
              tx_r <= {1'b0, tx_r[27:1]};
            end
            if (last_bit) begin
              if (!sample_r && then_read_r) begin
                sample_r <= 1'b1;
                doe_r    <= 1'b0;
                nbits_r  <= prog_link_pkg::RSP_BITS;
              end else begin
                doe_r <= 1'b0;
                if (sample_r) begin
                  rsp_valid_r <= 1'b1;
                  rsp_data_r  <= rx_nxt;
                  if (op_r == prog_link_pkg::OP_ID_CHECK) begin
                    resident_r    <= (rx_nxt == prog_link_pkg::ID_RESIDENT);
                    load_needed_r <= (rx_nxt != prog_link_pkg::ID_RESIDENT);
                  end
                  if (op_r == prog_link_pkg::OP_VERIFY && rx_nxt != cmp_r) begin
                    verr_r <= 1'b1;
                  end
                end
                if (seq_more) begin
                  idx_r <= idx_r + 6'h01;
                  st_r  <= H_FETCH;
                end else begin
                  st_r <= H_IDLE;
                end
              end
            end
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

endmodule : prog_host

// ### core/prog_link_pkg.sv
// Constants, command codes and instruction words for the serial programming link.
// Assumes one 200 MHz core clock on both ends and a link clock made by the programmer.
// Function
// - Identity word lives at executive location 0x8005BE.
// - Execute code moves memory word into visibility register.
// - Shift-out code clocks visibility register; then no-op.
// - Identity 0xBB means executive is resident.
// - Other identity means executive must be loaded.
// - Master clear low or power loss exits mode.
// - Read sequences start with two jumps, one no-op.
// - Identity read: page, pointer, target, no-op, read.
// - Table page 0x80 selects executive memory.
// - Programmer verifies executive by reading back, comparing.
// - Readout alternates low/high reads, two no-ops each.
// - Response low hold lasts at least 15 us.
// - Wait 5 us after release before clocking.
// - At least 10 us between response words.
// - Row program 1-4 ms plain, 0.8-2.6 enhanced.
// - Erase 1-4 ms plain, 0.8-2.6 ms enhanced.
package prog_link_pkg;

  localparam int CODE_W = 4;
  localparam int PAY_W  = 24;
  localparam int WORD_W = 16;

  localparam logic [3:0] CODE_EXEC      = 4'h0;
  localparam logic [3:0] CODE_SHIFT_OUT = 4'h1;
  localparam logic [3:0] OPC_MOV_LIT    = 4'h2;

  localparam logic [23:0] INSN_NOP        = 24'h000000;
  localparam logic [23:0] INSN_GOTO_RESET = 24'h040100;
  localparam logic [23:0] INSN_PAGE_LIT   = 24'h200800;
  localparam logic [23:0] INSN_W0_TO_PAGE = 24'h880190;
  localparam logic [23:0] INSN_PTR_LIT    = 24'h205BE0;
  localparam logic [23:0] INSN_VIS_TARGET = 24'h207841;
  localparam logic [23:0] INSN_RD_LOW_ID  = 24'hBA0890;
  localparam logic [23:0] INSN_CLR_RD_PTR = 24'hEB0300;
  localparam logic [23:0] INSN_CLR_WR_PTR = 24'hEB0380;
  localparam logic [23:0] INSN_RDL_KEEP   = 24'hBA1B96;
  localparam logic [23:0] INSN_RDH_INC    = 24'hBADBB6;
  localparam logic [23:0] INSN_RDH_PREINC = 24'hBADBD6;
  localparam logic [23:0] INSN_RDL_INC    = 24'hBA1BB6;

  localparam logic [15:0] VISI_ADDR   = 16'h0784;
  localparam logic [7:0]  EXEC_PAGE   = 8'h80;
  localparam logic [15:0] ID_PTR      = 16'h05BE;
  localparam logic [15:0] ID_RESIDENT = 16'h00BB;

  localparam logic [4:0] CODE_BITS = 5'h04;
  localparam logic [4:0] CMD_BITS  = 5'h1C;
  localparam logic [4:0] RSP_BITS  = 5'h10;

  localparam longint CLK_PS           = 5000;
  localparam longint RESP_LOW_US      = 15;
  localparam longint REL_CLK_US       = 5;
  localparam longint INTER_WORD_US    = 10;
  localparam longint ROW_PLAIN_MIN_US = 1000;
  localparam longint ROW_PLAIN_MAX_US = 4000;
  localparam longint ROW_ENH_MIN_US   = 800;
  localparam longint ROW_ENH_MAX_US   = 2600;

  // Least times round up, longest times round down
  localparam int RESP_LOW_CYC   = int'((RESP_LOW_US * 1000000 + CLK_PS - 1) / CLK_PS);
  localparam int REL_CLK_CYC    = int'((REL_CLK_US * 1000000 + CLK_PS - 1) / CLK_PS);
  localparam int INTER_WORD_CYC = int'((INTER_WORD_US * 1000000 + CLK_PS - 1) / CLK_PS);
  localparam int ROW_PLAIN_CYC  = int'((ROW_PLAIN_MAX_US * 1000000) / CLK_PS);
  localparam int ROW_ENH_CYC    = int'((ROW_ENH_MAX_US * 1000000) / CLK_PS);

  localparam logic [5:0] SEQ_ID_FIRST   = 6'h00;
  localparam logic [5:0] SEQ_ID_LAST    = 6'h0C;
  localparam logic [5:0] SEQ_EXEC_FIRST = 6'h10;
  localparam logic [5:0] SEQ_EXEC_BODY  = 6'h18;
  localparam logic [5:0] SEQ_EXEC_LAST  = 6'h2F;

  typedef enum logic [2:0] {
    OP_EXEC, OP_SHIFT_OUT, OP_ID_CHECK, OP_EXEC_READ,
    OP_VERIFY, OP_RESPONSE, OP_ROW_WAIT, OP_EXIT
  } op_t;

  function automatic logic is_mov_lit(input logic [23:0] w);
    return w[23:20] == OPC_MOV_LIT;
  endfunction : is_mov_lit

endpackage : prog_link_pkg

// ### core/prog_link_if.sv
// Serial programming link between programmer and device.
// Data pin is shared; an undriven pin reads high through the pull-up.
`timescale 1ns/10ps
interface prog_link_if;
  logic programming_clock_pin;
  logic master_clear_pin_n;
  logic host_dout;
  logic host_doe;
  logic dev_dout;
  logic dev_doe;
  logic pgd_level;

  assign pgd_level = (host_doe ? host_dout : 1'b1) & (dev_doe ? dev_dout : 1'b1);

  modport programmer (output programming_clock_pin, output master_clear_pin_n, output host_dout, output host_doe,
                      input pgd_level);
  modport device (input programming_clock_pin, input master_clear_pin_n, input pgd_level,
                  output dev_dout, output dev_doe);
endinterface : prog_link_if

// ### core/prog_device.sv
// Device end of the serial programming link: command shifter, small executor,
// visibility register shift-out and timed response.
// Assumes the programmer owns the link clock and master clear.
`timescale 1ns/10ps
module prog_device (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  prog_link_if.device      lnk,
  output logic [23:0]      mem_addr_o,
  output logic             mem_rd_o,
  input  wire logic [15:0] mem_data_i,
  input  wire logic        resp_valid_i,
  input  wire logic [15:0] resp_data_i,
  output logic             resp_ready_o,
  output logic             mode_active_o,
  output logic [7:0]       table_page_o
);

  typedef enum logic [1:0] {D_CODE, D_PAY, D_OUT, D_HOLD} dstate_t;

  dstate_t     st_r;
  logic [2:0]  pgc_s_r;
  logic [1:0]  pgd_s_r;
  logic [1:0]  master_clear_pin_s_r;
  logic [4:0]  cnt_r;
  logic [23:0] sh_r;
  logic [15:0] out_r;
  logic [11:0] hold_r;
  logic        dout_r;
  logic        doe_r;
  logic [15:0] w0_r;
  logic [15:0] w1_r;
  logic [7:0]  page_r;
  logic [15:0] visi_r;
  logic        rd_r;

  wire         active  = master_clear_pin_s_r[1];
  wire         rise    = pgc_s_r[1] & ~pgc_s_r[2];
  wire         fall    = ~pgc_s_r[1] & pgc_s_r[2];
  wire [23:0]  sh_nxt  = {pgd_s_r[1], sh_r[23:1]};
  wire [3:0]   code    = sh_nxt[23:20];
  wire         take_rsp = resp_valid_i & resp_ready_o;

  assign resp_ready_o  = active & (st_r == D_CODE) & (cnt_r == 5'h00);
  assign mem_addr_o    = {page_r, w0_r};
  assign mem_rd_o      = rd_r;
  assign mode_active_o = active;
  assign table_page_o  = page_r;
  assign lnk.dev_dout  = dout_r;
  assign lnk.dev_doe   = doe_r;

  // Pins cross two flops before anything looks at them
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pgc_s_r  <= 3'h0;
      pgd_s_r  <= 2'h3;
      master_clear_pin_s_r <= 2'h0;
    end else begin
      pgc_s_r  <= {pgc_s_r[1:0], lnk.programming_clock_pin};
      pgd_s_r  <= {pgd_s_r[0], lnk.pgd_level};
      master_clear_pin_s_r <= {master_clear_pin_s_r[0], lnk.master_clear_pin_n};
    end
  end

  // Read data is taken during the strobe cycle itself
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      visi_r <= 16'h0000;
    end else if (rd_r && w1_r == prog_link_pkg::VISI_ADDR) begin
      visi_r <= mem_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r   <= D_CODE;
      cnt_r  <= 5'h00;
      sh_r   <= 24'h000000;
      out_r  <= 16'h0000;
      hold_r <= 12'h000;
      dout_r <= 1'b1;
      doe_r  <= 1'b0;
      w0_r   <= 16'h0000;
      w1_r   <= 16'h0000;
      page_r <= 8'h00;
      rd_r   <= 1'b0;
    end else if (!active) begin
      // Master clear low returns to code state, clears the page and releases the pin
      st_r   <= D_CODE;
      cnt_r  <= 5'h00;
      doe_r  <= 1'b0;
      dout_r <= 1'b1;
      rd_r   <= 1'b0;
      page_r <= 8'h00;
    end else begin
      rd_r <= 1'b0;
      unique case (st_r)
        D_CODE: begin
          if (take_rsp) begin
            out_r  <= resp_data_i;
            hold_r <= 12'(prog_link_pkg::RESP_LOW_CYC);
            dout_r <= 1'b0;
            doe_r  <= 1'b1;
            st_r   <= D_HOLD;
          end else if (rise) begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == prog_link_pkg::CODE_BITS - 5'h01) begin
              cnt_r <= 5'h00;
              if (code == prog_link_pkg::CODE_SHIFT_OUT) begin
                out_r <= visi_r;
                st_r  <= D_OUT;
              end else begin
                st_r <= D_PAY;
              end
            end
          end
        end
        D_PAY: begin
          if (rise) begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == 5'(prog_link_pkg::PAY_W - 1)) begin
              cnt_r <= 5'h00;
              st_r  <= D_CODE;
              if (prog_link_pkg::is_mov_lit(sh_nxt) && sh_nxt[3:0] == 4'h0) begin
                w0_r <= sh_nxt[19:4];
              end
              if (prog_link_pkg::is_mov_lit(sh_nxt) && sh_nxt[3:0] == 4'h1) begin
                w1_r <= sh_nxt[19:4];
              end
              if (sh_nxt == prog_link_pkg::INSN_W0_TO_PAGE) begin
                page_r <= w0_r[7:0];
              end
              if (sh_nxt == prog_link_pkg::INSN_RD_LOW_ID) begin
                rd_r <= 1'b1;
              end
            end
          end
        end
        D_HOLD: begin
          // Pin held low for the whole response delay before release
          hold_r <= hold_r - 12'h001;
          if (hold_r == 12'h001) begin
            doe_r  <= 1'b0;
            dout_r <= 1'b1;
            st_r   <= D_OUT;
          end
        end
        D_OUT: begin
          if (rise) begin
            doe_r  <= 1'b1;
            dout_r <= out_r[0];
            out_r  <= {1'b0, out_r[15:1]};
            cnt_r  <= cnt_r + 5'h01;
          end else if (fall && cnt_r == prog_link_pkg::RSP_BITS) begin
            doe_r  <= 1'b0;
            dout_r <= 1'b1;
            cnt_r  <= 5'h00;
            st_r   <= D_CODE;
          end
        end
      endcase
    end
  end

endmodule : prog_device

// ### dv/prog_link_properties.sv
// Checker on the programming link wires, placed beside the interface.
// Assumes HALF_CYC equals the half period of the programmer end.
`timescale 1ns/10ps
module prog_link_properties #(
  parameter int HALF_CYC = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic programming_clock_pin,
  input wire logic master_clear_pin_n,
  input wire logic host_dout,
  input wire logic host_doe,
  input wire logic dev_dout,
  input wire logic dev_doe,
  input wire logic pgd_level
);
  int low_r;
  int hi_r;
  int rel_r;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_r <= 0;
      hi_r  <= 0;
      rel_r <= 0;
    end else begin
      low_r <= (dev_doe && !dev_dout && !programming_clock_pin) ? low_r + 1 : 0;
      hi_r  <= programming_clock_pin ? hi_r + 1 : 0;
      // Only a long low hold arms this; short shift-out lows do not
      rel_r <= (!dev_doe && low_r > 100) ? 1 : (programming_clock_pin || rel_r == 0) ? 0 : rel_r + 1;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  chk_no_contention:
    assert property (!(host_doe && dev_doe)) else $error("Data pin driven by both ends");
  chk_resp_low_hold:
    assert property ($fell(dev_doe) && low_r > 100 |-> low_r >= prog_link_pkg::RESP_LOW_CYC - 1)
      else $error("Response low hold too short");
  chk_release_wait:
    assert property ($rose(programming_clock_pin) && rel_r != 0 |-> rel_r >= prog_link_pkg::REL_CLK_CYC)
      else $error("Clock too soon after release");
  chk_mode_exit:
    assert property (!master_clear_pin_n [*4] |-> !dev_doe) else $error("Device drives out of mode");
  chk_half_period:
    assert property ($fell(programming_clock_pin) |-> hi_r == HALF_CYC) else $error("Link clock high time wrong");
  chk_host_hold:
    assert property (programming_clock_pin && $past(programming_clock_pin) && host_doe |-> $stable(host_dout))
      else $error("Host data moved while clock high");
  chk_dev_hold:
    assert property (!programming_clock_pin && !$past(programming_clock_pin) && dev_doe && $past(dev_doe) |-> $stable(dev_dout))
      else $error("Device data moved while clock low");
  chk_quiet_clock:
    assert property (!master_clear_pin_n |-> !programming_clock_pin) else $error("Link clock runs out of mode");
  cov_response: cover property ($fell(dev_doe) && low_r > 100);
  cov_exit: cover property ($fell(master_clear_pin_n));
  cov_dev_low: cover property ($fell(pgd_level) && dev_doe);
endmodule : prog_link_properties

// ### dv/tb_serial_program_exec_id_reader.sv
// Bench joining both link ends; ordinary cases run from a table.
// Assumes a 200 MHz core clock; row times are shortened by parameters.
`timescale 1ns/10ps
module tb_serial_program_exec_id_reader;
  typedef struct {prog_link_pkg::op_t op; logic [23:0] d; logic [15:0] id;
                  logic res; int n;} row_t;
  row_t rows[4] = '{'{prog_link_pkg::OP_ID_CHECK, 24'h0, 16'h00BB, 1'b1, 356},
    '{prog_link_pkg::OP_SHIFT_OUT, 24'h0, 16'h00BB, 1'b1, 20},
    '{prog_link_pkg::OP_ID_CHECK, 24'h0, 16'h00BA, 1'b0, 356},
    '{prog_link_pkg::OP_EXEC, 24'h040100, 16'h00BA, 1'b0, 28}};
  logic clk = 1'b0, rst_b = 1'b0, cv = 1'b0, ce = 1'b0, rv = 1'b0, pq = 1'b0;
  prog_link_pkg::op_t co = prog_link_pkg::OP_EXEC;
  logic [23:0] cd = 24'h0;
  logic [15:0] rdat = 16'h0, idw = 16'h0, md = 16'h0;
  logic [27:0] fr = 28'h0;
  int rises = 0, offs = 0, rdn = 0, err_total = 0, cmp_count = 0, cyc, r0, o0;
  logic rdy, sv, resd, ld, ve, mrd, rrdy, act;
  logic [15:0] sd;
  logic [23:0] adr;
  logic [7:0] pg;
  prog_link_if lnk ();
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    md <= (adr == 24'h8005BE) ? idw : 16'h1234;
    pq <= lnk.programming_clock_pin;
    if (!act) offs <= offs + 1;
    if (mrd === 1'b1) rdn <= rdn + 1;
    if (lnk.programming_clock_pin && !pq) begin
      rises <= rises + 1;
      fr <= {lnk.pgd_level, fr[27:1]};
    end
  end
  prog_host #(.HALF_CYC(8), .PLAIN_CYC(50), .ENH_CYC(30), .EXIT_CYC(16)) u_prog_host (
    .core_clk_i(clk), .rst_b_i(rst_b), .lnk(lnk.programmer), .cmd_valid_i(cv),
    .cmd_op_i(co), .cmd_data_i(cd), .cmd_enh_i(ce), .cmd_ready_o(rdy), .rsp_valid_o(sv),
    .rsp_data_o(sd), .exec_resident_o(resd), .exec_load_needed_o(ld), .verify_error_o(ve));
  prog_device u_prog_device (
    .core_clk_i(clk), .rst_b_i(rst_b), .lnk(lnk.device), .mem_addr_o(adr), .mem_rd_o(mrd),
    .mem_data_i(md), .resp_valid_i(rv), .resp_data_i(rdat), .resp_ready_o(rrdy),
    .mode_active_o(act), .table_page_o(pg));
  prog_link_properties #(.HALF_CYC(8)) u_prog_link_properties (
    .core_clk_i(clk), .rst_b_i(rst_b), .programming_clock_pin(lnk.programming_clock_pin), .master_clear_pin_n(lnk.master_clear_pin_n),
    .host_dout(lnk.host_dout), .host_doe(lnk.host_doe), .dev_dout(lnk.dev_dout),
    .dev_doe(lnk.dev_doe), .pgd_level(lnk.pgd_level));
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic cmp(input string nm, input logic [27:0] e, input logic [27:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic run(input prog_link_pkg::op_t op, input logic [23:0] d, input logic e);
    logic got;
    logic rd;
    got = 1'b0;
    rd = op inside {prog_link_pkg::OP_SHIFT_OUT, prog_link_pkg::OP_ID_CHECK,
                    prog_link_pkg::OP_VERIFY, prog_link_pkg::OP_RESPONSE};
    cyc = 0;
    r0 = rises;
    @(posedge clk);
    co <= op;
    cd <= d;
    ce <= e;
    cv <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      got = got | (sv === 1'b1);
      cyc++;
    end while (!(rdy === 1'b1 && (got || !rd)) && cyc < 20000);
    if (cyc >= 20000) begin
      err_total++;
      test_done();
    end
  endtask : run
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      idw <= rows[i].id;
      run(rows[i].op, rows[i].d, 1'b0);
      cmp("rises", 28'(rows[i].n), 28'(rises - r0));
      if (rows[i].op != prog_link_pkg::OP_EXEC) cmp("word", 28'(rows[i].id), 28'(sd));
      cmp("resident", 28'(rows[i].res), 28'(resd));
      cmp("load", 28'(!rows[i].res), 28'(ld));
    end
    cmp("frame", {24'h040100, prog_link_pkg::CODE_EXEC}, fr);
    cmp("page", 28'(prog_link_pkg::EXEC_PAGE), 28'(pg));
    cmp("addr", 28'(24'h8005BE), 28'(adr));
    cmp("mem_reads", 28'(2), 28'(rdn));
    run(prog_link_pkg::OP_VERIFY, 24'h0000BA, 1'b0);
    cmp("verify_ok", 28'(0), 28'(ve));
    run(prog_link_pkg::OP_VERIFY, 24'h001111, 1'b0);
    cmp("verify_bad", 28'(1), 28'(ve));
    run(prog_link_pkg::OP_EXEC, 24'h200000, 1'b0);
    run(prog_link_pkg::OP_EXEC, prog_link_pkg::INSN_W0_TO_PAGE, 1'b0);
    cmp("page_user", 28'(0), 28'(pg));
    run(prog_link_pkg::OP_EXEC_READ, 24'h0, 1'b0);
    cmp("page_exec", 28'(prog_link_pkg::EXEC_PAGE), 28'(pg));
    cmp("exec_rises", 28'(896), 28'(rises - r0));
    for (int e = 0; e < 2; e++) begin
      run(prog_link_pkg::OP_ROW_WAIT, 24'h0, e[0]);
      cmp("row_time", 28'(1), 28'(cyc >= (e ? 28 : 48) && cyc <= (e ? 34 : 54)));
      cmp("row_quiet", 28'(0), 28'(rises - r0));
    end
    @(posedge clk);
    rv <= 1'b1;
    rdat <= 16'hA55A;
    cyc = 0;
    #1;
    while (rrdy !== 1'b1 && cyc < 100) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    if (cyc >= 100) begin
      err_total++;
      test_done();
    end
    @(posedge clk);
    rv <= 1'b0;
    #1;
    cmp("resp_taken", 28'(0), 28'(rrdy));
    run(prog_link_pkg::OP_RESPONSE, 24'h0, 1'b0);
    cmp("resp_word", 28'(16'hA55A), 28'(sd));
    cmp("resp_rises", 28'(16), 28'(rises - r0));
    o0 = offs;
    run(prog_link_pkg::OP_EXIT, 24'h0, 1'b0);
    cmp("mode_left", 28'(1), 28'(offs > o0));
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    cmp("reset_state", 28'h0, {ve, resd, ld, act, pg, sd});
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    cmp("reset_ready", 28'(3), 28'({act, rdy}));
    test_done();
  end
endmodule : tb_serial_program_exec_id_reader
